// [hdl/mfcfg_map.svh]
`ifndef MFCFG_MAP_SVH
`define MFCFG_MAP_SVH
// ****************************************
// Register addresses
// ****************************************
`define MFCFG_ADDR_TXCFG 5'h0C
`define MFCFG_ADDR_RXCFG 5'h0D
`define MFCFG_ADDR_DRV 5'h0E
`define MFCFG_ADDR_REV 5'h0F
`define MFCFG_ADDR_AMPG 5'h10
`define MFCFG_ADDR_AMPS 5'h11
`define MFCFG_ADDR_STAND 5'h12
`define MFCFG_ADDR_BIAS 5'h13
// ****************************************
// Writable bit masks, undefined bits held at zero
// ****************************************
`define MFCFG_MASK_TXCFG 8'hD7
`define MFCFG_MASK_RXCFG 8'hF7
`define MFCFG_MASK_DRV 8'h81
`define MFCFG_MASK_AMPG 8'hF7
`define MFCFG_MASK_AMPS 8'h77
`define MFCFG_MASK_STAND 8'h77
`define MFCFG_MASK_BIAS 8'hFF
// ****************************************
// Field positions
// ****************************************
`define MFCFG_BIT_INTERP_HI 7
`define MFCFG_BIT_INTERP_LO 6
`define MFCFG_BIT_INVERT 4
`define MFCFG_BIT_NIBBLE 2
`define MFCFG_BIT_NEG_EDGE 1
`define MFCFG_BIT_TWOS 0
`define MFCFG_BIT_ALOOP 7
`define MFCFG_BIT_DLOOP 6
`define MFCFG_BIT_RX3ST 5
`define MFCFG_BIT_LOWDRV 7
`define MFCFG_BIT_DACSEL 0
`define MFCFG_SAMPLE_MSB 11
// ****************************************
// Reset values and counts
// ****************************************
`define MFCFG_INTERP_2X 2'h1
`define MFCFG_INTERP_BYP 2'h0
`define MFCFG_RST_DRV 8'h00
`define MFCFG_RST_AMPG 8'h44
`define MFCFG_RST_AMPS 8'h62
`define MFCFG_RST_STAND 8'h01
`define MFCFG_RST_BIAS 8'h00
`define MFCFG_BIT_LAST 3'h7
`endif

// [hdl/mfcfg_pkg.sv]
package mfcfg_pkg;
  typedef logic [11:0] mfcfg_sample_t;
  typedef logic [4:0] mfcfg_addr_t;
  typedef logic [7:0] mfcfg_byte_t;
  typedef enum logic [2:0] {
    SP_IDLE = 3'b000,
    SP_INSTR = 3'b001,
    SP_WDATA = 3'b010,
    SP_RDATA = 3'b011,
    SP_DONE = 3'b100
  } mfcfg_spi_st_t;
endpackage : mfcfg_pkg

// [hdl/mfcfg_bus_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface mfcfg_bus_if;
  import mfcfg_pkg::*;
  logic wr_stb;
  mfcfg_addr_t wr_addr;
  mfcfg_byte_t wr_data;
  mfcfg_addr_t rd_addr;
  mfcfg_byte_t rd_data;
  modport spi (output wr_stb, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport regs (input wr_stb, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : mfcfg_bus_if
`default_nettype wire

// [hdl/mfcfg_spi.sv]
`timescale 1ns/1ps
`default_nettype none
`include "mfcfg_map.svh"
module mfcfg_spi (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic sen_b,
  input wire logic sdio_in,
  input wire logic spi_lsb_first,
  input wire logic spi_four_wire,
  output logic sdio_out,
  output logic sdio_oe,
  output logic sdo_out,
  output logic sdo_oe,
  mfcfg_bus_if.spi bus
);
  import mfcfg_pkg::*;

  mfcfg_spi_st_t st_reg, st_next;
  logic sclk_q_reg, sclk_q_next;
  logic [2:0] bit_cnt_reg, bit_cnt_next;
  logic [1:0] byte_cnt_reg, byte_cnt_next;
  mfcfg_addr_t addr_reg, addr_next, wr_addr_reg, wr_addr_next;
  mfcfg_byte_t sh_reg, sh_next, wr_data_reg, wr_data_next;
  logic wr_stb_reg, wr_stb_next;
  logic out_bit_reg, out_bit_next, out_en_reg, out_en_next;
  logic rise, fall;
  mfcfg_byte_t shin, rbyte;

  function automatic mfcfg_addr_t next_addr(input mfcfg_addr_t a, input logic lsb);
    next_addr = lsb ? mfcfg_addr_t'(a + 5'h01) : mfcfg_addr_t'(a - 5'h01);
  endfunction : next_addr

  assign rise = sclk & ~sclk_q_reg;
  assign fall = ~sclk & sclk_q_reg;
  assign shin = spi_lsb_first ? {sdio_in, sh_reg[7:1]} : {sh_reg[6:0], sdio_in};
  assign rbyte = (bit_cnt_reg == 3'h0) ? bus.rd_data : sh_reg;

  always_comb begin
    st_next = st_reg;
    sclk_q_next = sclk;
    bit_cnt_next = bit_cnt_reg;
    byte_cnt_next = byte_cnt_reg;
    addr_next = addr_reg;
    wr_addr_next = wr_addr_reg;
    sh_next = sh_reg;
    wr_data_next = wr_data_reg;
    wr_stb_next = 1'b0;
    out_bit_next = out_bit_reg;
    out_en_next = out_en_reg;
    if (sen_b) begin
      st_next = SP_IDLE;
      out_en_next = 1'b0;
    end else begin
      unique case (st_reg)
        SP_IDLE: begin
          st_next = SP_INSTR;
          bit_cnt_next = 3'h0;
        end
        SP_INSTR: if (rise) begin
          sh_next = shin;
          bit_cnt_next = bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == `MFCFG_BIT_LAST) begin
            st_next = shin[7] ? SP_RDATA : SP_WDATA;
            byte_cnt_next = shin[6:5];
            addr_next = shin[4:0];
          end
        end
        SP_WDATA: if (rise) begin
          sh_next = shin;
          bit_cnt_next = bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == `MFCFG_BIT_LAST) begin
            wr_stb_next = 1'b1;
            wr_data_next = shin;
            wr_addr_next = addr_reg;
            addr_next = next_addr(addr_reg, spi_lsb_first);
            byte_cnt_next = byte_cnt_reg - 2'h1;
            if (byte_cnt_reg == 2'h0) begin
              st_next = SP_DONE;
            end
          end
        end
        SP_RDATA: if (fall) begin
          out_en_next = 1'b1;
          out_bit_next = spi_lsb_first ? rbyte[0] : rbyte[7];
          sh_next = spi_lsb_first ? {1'b0, rbyte[7:1]} : {rbyte[6:0], 1'b0};
          bit_cnt_next = bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == `MFCFG_BIT_LAST) begin
            addr_next = next_addr(addr_reg, spi_lsb_first);
            byte_cnt_next = byte_cnt_reg - 2'h1;
            if (byte_cnt_reg == 2'h0) begin
              st_next = SP_DONE;
            end
          end
        end
        SP_DONE: if (fall) begin
          out_en_next = 1'b0;
        end
        default: st_next = SP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st_reg <= SP_IDLE;
      sclk_q_reg <= 1'b0;
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= 2'h0;
      addr_reg <= 5'h00;
      wr_addr_reg <= 5'h00;
      sh_reg <= 8'h00;
      wr_data_reg <= 8'h00;
      wr_stb_reg <= 1'b0;
      out_bit_reg <= 1'b0;
      out_en_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      sclk_q_reg <= sclk_q_next;
      bit_cnt_reg <= bit_cnt_next;
      byte_cnt_reg <= byte_cnt_next;
      addr_reg <= addr_next;
      wr_addr_reg <= wr_addr_next;
      sh_reg <= sh_next;
      wr_data_reg <= wr_data_next;
      wr_stb_reg <= wr_stb_next;
      out_bit_reg <= out_bit_next;
      out_en_reg <= out_en_next;
    end
  end

  assign bus.wr_stb = wr_stb_reg;
  assign bus.wr_addr = wr_addr_reg;
  assign bus.wr_data = wr_data_reg;
  assign bus.rd_addr = addr_reg;
  assign sdio_out = out_bit_reg;
  assign sdo_out = out_bit_reg;
  assign sdio_oe = out_en_reg & ~spi_four_wire;
  assign sdo_oe = out_en_reg & spi_four_wire;

  a_addr_step: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!sen_b && st_reg == SP_WDATA && rise && bit_cnt_reg == `MFCFG_BIT_LAST) |=>
      addr_reg == ($past(spi_lsb_first) ? $past(addr_reg) + 5'h01 : $past(addr_reg) - 5'h01))
    else $error("Write address did not step");
endmodule : mfcfg_spi
`default_nettype wire

// [hdl/mfcfg_regs.sv]
// What this block does
// - Interpolation field powers up 01, or 00 in half-duplex with default-set high.
// - Format bit of transmit and receive registers defaults 0 half, 1 full duplex.
// - Analog loopback bit routes received samples into the transmit converter path.
// - Digital loopback bit, full-duplex only, sends transmit input to receive output.
// - Drive-strength and converter-output-select bits default to zero in every mode.
// - Duplex and default-set pins pick one of three power-up register sets.
// - Half-duplex uses transmit enable to keep the unused path in low power.
// - Legacy three-bit gain map defaults on only for half-duplex with default-set high.
// - Secondary-stage gain register resets to 0x62.
// - Amplifier gain register holds a 4-bit and a 3-bit step and resets to 0x44.
// - In half-duplex, default-set pin chooses interpolation ratio and gain-map defaults.
// - Multibyte transfers decrement address MSB-first and increment it LSB-first.
`timescale 1ns/1ps
`default_nettype none
`include "mfcfg_map.svh"
module mfcfg_regs #(
  parameter logic [3:0] REVISION_IDENTIFIER = 4'h5 // Arbitrary value
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic duplex_mode,
  input wire logic default_set,
  input wire logic tx_port_enable,
  input wire logic rx_port_enable,
  input wire logic sclk,
  input wire logic sen_b,
  input wire logic sdio_in,
  input wire logic spi_lsb_first,
  input wire logic spi_four_wire,
  input wire mfcfg_pkg::mfcfg_sample_t tx_sample,
  input wire mfcfg_pkg::mfcfg_sample_t adc_sample,
  output logic sdio_out,
  output logic sdio_oe,
  output logic sdo_out,
  output logic sdo_oe,
  output mfcfg_pkg::mfcfg_sample_t dac_sample,
  output mfcfg_pkg::mfcfg_sample_t rx_sample_out,
  output logic rx_out_enable,
  output logic tx_path_low_power,
  output logic rx_path_low_power,
  output logic [1:0] tx_interp,
  output logic tx_clk_neg_edge,
  output logic rx_clk_neg_edge,
  output logic tx_ls_nibble_first,
  output logic rx_ls_nibble_first,
  output logic low_drive,
  output logic dac_out_select,
  output logic rx_gain_map3,
  output mfcfg_pkg::mfcfg_byte_t amp_gain,
  output mfcfg_pkg::mfcfg_byte_t amp_stage_gain,
  output mfcfg_pkg::mfcfg_byte_t amp_stand,
  output mfcfg_pkg::mfcfg_byte_t rx_bias
);
  import mfcfg_pkg::*;

  mfcfg_bus_if bus ();

  mfcfg_spi u_spi (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .sclk(sclk),
    .sen_b(sen_b),
    .sdio_in(sdio_in),
    .spi_lsb_first(spi_lsb_first),
    .spi_four_wire(spi_four_wire),
    .sdio_out(sdio_out),
    .sdio_oe(sdio_oe),
    .sdo_out(sdo_out),
    .sdo_oe(sdo_oe),
    .bus(bus.spi)
  );

  // ****************************************
  // Configuration registers
  // ****************************************
  logic mode_full_reg, mode_full_next, map3_reg, map3_next;
  mfcfg_byte_t tx_cfg_reg, tx_cfg_next, rx_cfg_reg, rx_cfg_next, drv_reg, drv_next;
  mfcfg_byte_t ampg_reg, ampg_next, amps_reg, amps_next;
  mfcfg_byte_t stand_reg, stand_next, bias_reg, bias_next;
  logic half_alt;

  // Straps are sampled throughout reset so the defaults follow the pins at release
  assign half_alt = ~duplex_mode & default_set;

  always_comb begin
    mode_full_next = mode_full_reg;
    map3_next = map3_reg;
    tx_cfg_next = tx_cfg_reg;
    rx_cfg_next = rx_cfg_reg;
    drv_next = drv_reg;
    ampg_next = ampg_reg;
    amps_next = amps_reg;
    stand_next = stand_reg;
    bias_next = bias_reg;
    if (!rst_b) begin
      mode_full_next = duplex_mode;
      map3_next = half_alt;
      tx_cfg_next = 8'h00;
      tx_cfg_next[`MFCFG_BIT_INTERP_HI:`MFCFG_BIT_INTERP_LO] =
        half_alt ? `MFCFG_INTERP_BYP : `MFCFG_INTERP_2X;
      tx_cfg_next[`MFCFG_BIT_TWOS] = duplex_mode;
      rx_cfg_next = 8'h00;
      rx_cfg_next[`MFCFG_BIT_TWOS] = duplex_mode;
      drv_next = `MFCFG_RST_DRV;
      ampg_next = `MFCFG_RST_AMPG;
      amps_next = `MFCFG_RST_AMPS;
      stand_next = `MFCFG_RST_STAND;
      bias_next = `MFCFG_RST_BIAS;
    end else if (bus.wr_stb) begin
      // Undefined bits are dropped, so a careless host still reads zeros there
      unique case (bus.wr_addr)
        `MFCFG_ADDR_TXCFG: tx_cfg_next = bus.wr_data & `MFCFG_MASK_TXCFG;
        `MFCFG_ADDR_RXCFG: rx_cfg_next = bus.wr_data & `MFCFG_MASK_RXCFG;
        `MFCFG_ADDR_DRV: drv_next = bus.wr_data & `MFCFG_MASK_DRV;
        `MFCFG_ADDR_AMPG: ampg_next = bus.wr_data & `MFCFG_MASK_AMPG;
        `MFCFG_ADDR_AMPS: amps_next = bus.wr_data & `MFCFG_MASK_AMPS;
        `MFCFG_ADDR_STAND: stand_next = bus.wr_data & `MFCFG_MASK_STAND;
        `MFCFG_ADDR_BIAS: bias_next = bus.wr_data & `MFCFG_MASK_BIAS;
        default: ; // Revision and foreign addresses ignore writes
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    mode_full_reg <= mode_full_next;
    map3_reg <= map3_next;
    tx_cfg_reg <= tx_cfg_next;
    rx_cfg_reg <= rx_cfg_next;
    drv_reg <= drv_next;
    ampg_reg <= ampg_next;
    amps_reg <= amps_next;
    stand_reg <= stand_next;
    bias_reg <= bias_next;
  end

  // Read side; addresses outside this bank read zero
  always_comb begin
    unique case (bus.rd_addr)
      `MFCFG_ADDR_TXCFG: bus.rd_data = tx_cfg_reg;
      `MFCFG_ADDR_RXCFG: bus.rd_data = rx_cfg_reg;
      `MFCFG_ADDR_DRV: bus.rd_data = drv_reg;
      `MFCFG_ADDR_REV: bus.rd_data = {4'h0, REVISION_IDENTIFIER};
      `MFCFG_ADDR_AMPG: bus.rd_data = ampg_reg;
      `MFCFG_ADDR_AMPS: bus.rd_data = amps_reg;
      `MFCFG_ADDR_STAND: bus.rd_data = stand_reg;
      `MFCFG_ADDR_BIAS: bus.rd_data = bias_reg;
      default: bus.rd_data = 8'h00;
    endcase
  end

  // ****************************************
  // Sample path and power control
  // ****************************************
  // Internal samples are twos complement; straight binary differs only in the MSB
  function automatic mfcfg_sample_t fmt_swap(input mfcfg_sample_t s, input logic twos);
    fmt_swap = twos ? s : {~s[`MFCFG_SAMPLE_MSB], s[`MFCFG_SAMPLE_MSB-1:0]};
  endfunction : fmt_swap

  mfcfg_sample_t dac_reg, dac_next, rxo_reg, rxo_next, tx_int;
  logic tx_lp_reg, tx_lp_next, rx_lp_reg, rx_lp_next, rx_port_enable_reg, rx_port_enable_next;
  logic dloop, tx_port_enable_eff, rx_port_enable_eff;

  assign tx_int = fmt_swap(tx_sample, tx_cfg_reg[`MFCFG_BIT_TWOS]);
  assign dloop = rx_cfg_reg[`MFCFG_BIT_DLOOP] & mode_full_reg;
  assign tx_port_enable_eff = tx_port_enable ^ tx_cfg_reg[`MFCFG_BIT_INVERT];
  assign rx_port_enable_eff = rx_port_enable ^ rx_cfg_reg[`MFCFG_BIT_INVERT];

  always_comb begin
    dac_next = rx_cfg_reg[`MFCFG_BIT_ALOOP] ? adc_sample : tx_int;
    rxo_next = fmt_swap(dloop ? tx_int : adc_sample, rx_cfg_reg[`MFCFG_BIT_TWOS]);
    tx_lp_next = ~mode_full_reg & ~tx_port_enable_eff;
    rx_lp_next = ~mode_full_reg & tx_port_enable_eff;
    rx_port_enable_next = mode_full_reg ? ~rx_cfg_reg[`MFCFG_BIT_RX3ST] : rx_port_enable_eff;
    if (!rst_b) begin
      dac_next = 12'h000;
      rxo_next = 12'h000;
      tx_lp_next = 1'b0;
      rx_lp_next = 1'b0;
      rx_port_enable_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    dac_reg <= dac_next;
    rxo_reg <= rxo_next;
    tx_lp_reg <= tx_lp_next;
    rx_lp_reg <= rx_lp_next;
    rx_port_enable_reg <= rx_port_enable_next;
  end

  assign dac_sample = dac_reg;
  assign rx_sample_out = rxo_reg;
  assign rx_out_enable = rx_port_enable_reg;
  assign tx_path_low_power = tx_lp_reg;
  assign rx_path_low_power = rx_lp_reg;
  assign tx_interp = tx_cfg_reg[`MFCFG_BIT_INTERP_HI:`MFCFG_BIT_INTERP_LO];
  assign tx_clk_neg_edge = tx_cfg_reg[`MFCFG_BIT_NEG_EDGE];
  assign rx_clk_neg_edge = rx_cfg_reg[`MFCFG_BIT_NEG_EDGE];
  assign low_drive = drv_reg[`MFCFG_BIT_LOWDRV];
  assign dac_out_select = drv_reg[`MFCFG_BIT_DACSEL];
  assign rx_gain_map3 = map3_reg;
  assign amp_gain = ampg_reg;
  assign amp_stage_gain = amps_reg;
  assign amp_stand = stand_reg;
  assign rx_bias = bias_reg;

  // Nibble order is meaningless in half-duplex, so it is forced off there
  logic tx_nib_reg, tx_nib_next, rx_nib_reg, rx_nib_next;
  always_comb begin
    tx_nib_next = tx_cfg_reg[`MFCFG_BIT_NIBBLE] & mode_full_reg;
    rx_nib_next = rx_cfg_reg[`MFCFG_BIT_NIBBLE] & mode_full_reg;
  end
  always_ff @(posedge clk_sys) begin
    tx_nib_reg <= tx_nib_next;
    rx_nib_reg <= rx_nib_next;
  end
  assign tx_ls_nibble_first = tx_nib_reg;
  assign rx_ls_nibble_first = rx_nib_reg;

  // ****************************************
  // Checks
  // ****************************************
  a_interp_default: assert property (@(posedge clk_sys) $rose(rst_b) |->
    tx_interp == ((!$past(duplex_mode) && $past(default_set)) ? 2'h0 : 2'h1))
    else $error("Interpolation default wrong after reset");
  a_format_default: assert property (@(posedge clk_sys) $rose(rst_b) |->
    tx_cfg_reg[0] == $past(duplex_mode) && rx_cfg_reg[0] == $past(duplex_mode))
    else $error("Sample format default wrong after reset");
  a_analog_loop: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rx_cfg_reg[7] |=> dac_sample == $past(adc_sample))
    else $error("Analog loopback did not feed the converter");
  a_digital_loop: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (rx_cfg_reg[6] && mode_full_reg && rx_cfg_reg[0] && tx_cfg_reg[0])
    |=> rx_sample_out == $past(tx_sample))
    else $error("Digital loopback did not reach receive output");
  a_drive_default: assert property (@(posedge clk_sys) $rose(rst_b) |->
    !low_drive && !dac_out_select)
    else $error("Drive or output select default wrong");
  a_gain_defaults: assert property (@(posedge clk_sys) $rose(rst_b) |->
    amp_gain == 8'h44 && amp_stage_gain == 8'h62 && amp_stand == 8'h01)
    else $error("Amplifier register defaults wrong");
  a_map3_default: assert property (@(posedge clk_sys) $rose(rst_b) |->
    rx_gain_map3 == (!$past(duplex_mode) && $past(default_set)))
    else $error("Gain map default wrong");
  a_half_power: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!mode_full_reg && $past(rst_b)) |=> tx_path_low_power != rx_path_low_power)
    else $error("Half-duplex path power select wrong");
  a_nibble_half: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !mode_full_reg |=> !tx_ls_nibble_first && !rx_ls_nibble_first)
    else $error("Nibble order active in half-duplex");
  a_rev_readonly: assert property (@(posedge clk_sys) disable iff (!rst_b)
    bus.rd_addr == 5'h0F |-> bus.rd_data == {4'h0, REVISION_IDENTIFIER})
    else $error("Revision identifier not constant");
  a_write_applies: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (bus.wr_stb && bus.wr_addr == 5'h10) |=> amp_gain == ($past(bus.wr_data) & 8'hF7))
    else $error("Written gain value not applied");
  a_full_power: assert property (@(posedge clk_sys) disable iff (!rst_b)
    mode_full_reg |=> !tx_path_low_power && !rx_path_low_power)
    else $error("Full-duplex path left in low power");
  a_half_select: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !mode_full_reg |=> rx_path_low_power ==
      ($past(tx_port_enable) ^ $past(tx_cfg_reg[`MFCFG_BIT_INVERT])))
    else $error("Transmit enable did not pick the active path");
  a_half_rx_enable: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !mode_full_reg |=> rx_out_enable ==
      ($past(rx_port_enable) ^ $past(rx_cfg_reg[`MFCFG_BIT_INVERT])))
    else $error("Receive output enable wrong in half-duplex");
  a_nibble_full: assert property (@(posedge clk_sys) disable iff (!rst_b)
    mode_full_reg |=> tx_ls_nibble_first == $past(tx_cfg_reg[`MFCFG_BIT_NIBBLE]) &&
      rx_ls_nibble_first == $past(rx_cfg_reg[`MFCFG_BIT_NIBBLE]))
    else $error("Nibble order not applied in full-duplex");
  a_tx_loop_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!rx_cfg_reg[`MFCFG_BIT_ALOOP] && tx_cfg_reg[`MFCFG_BIT_TWOS]) |=>
      dac_sample == $past(tx_sample))
    else $error("Transmit samples not reaching the converter");
  a_rev_ignored: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (bus.wr_stb && bus.wr_addr == `MFCFG_ADDR_REV) |=> $stable(tx_cfg_reg) &&
      $stable(rx_cfg_reg) && $stable(drv_reg) && $stable(ampg_reg) &&
      $stable(amps_reg) && $stable(stand_reg) && $stable(bias_reg))
    else $error("Write to revision address changed a register");
  a_tx_write_mask: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (bus.wr_stb && bus.wr_addr == `MFCFG_ADDR_TXCFG) |=>
      tx_cfg_reg == ($past(bus.wr_data) & `MFCFG_MASK_TXCFG))
    else $error("Transmit interface write not masked");
  a_drive_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (bus.wr_stb && bus.wr_addr == `MFCFG_ADDR_DRV) |=>
      low_drive == $past(bus.wr_data[`MFCFG_BIT_LOWDRV]) &&
      dac_out_select == $past(bus.wr_data[`MFCFG_BIT_DACSEL]))
    else $error("Drive register write not applied");
  // Straps only move under reset, so the gain map flag must hold after it
  a_map3_stable: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $past(rst_b) |-> $stable(rx_gain_map3))
    else $error("Gain map flag moved outside reset");
  c_write_seen: cover property (@(posedge clk_sys) disable iff (!rst_b) bus.wr_stb);
  c_analog_loop: cover property (@(posedge clk_sys) disable iff (!rst_b) rx_cfg_reg[7]);
  c_read_out: cover property (@(posedge clk_sys) disable iff (!rst_b) sdio_oe || sdo_oe);
  c_digital_loop: cover property (@(posedge clk_sys) disable iff (!rst_b) dloop);
  c_half_swap: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(tx_path_low_power));
endmodule : mfcfg_regs
`default_nettype wire

// [dv/mfcfg_host.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Serial host model
// ****************************************
module mfcfg_host (
  input wire logic clk_sys,
  input wire logic lsb_first,
  input wire logic four_wire,
  input wire logic sdio_rd,
  input wire logic sdo_out,
  output logic sclk,
  output logic sen_b,
  output logic sdio
);
  initial begin
    sclk = 1'b0;
    sen_b = 1'b1;
    sdio = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wait_clk

  // Low phase of 3 cycles leaves room for the 1-edge read data latency
  task automatic bit_io(input logic b, output logic r);
    sdio = b;
    wait_clk(3);
    r = four_wire ? sdo_out : sdio_rd;
    sclk = 1'b1;
    wait_clk(2);
    sclk = 1'b0;
  endtask : bit_io

  task automatic frame(input logic rw, input logic [1:0] n, input logic [4:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
    logic [7:0] h;
    logic r;
    int j;
    h = {rw, n, a};
    rd = '0;
    sen_b = 1'b0;
    wait_clk(2);
    for (int i = 0; i < 8; i++) begin
      bit_io(lsb_first ? h[i] : h[7-i], r);
    end
    for (int k = 0; k <= n; k++) begin
      for (int i = 0; i < 8; i++) begin
        j = lsb_first ? i : 7 - i;
        bit_io(wd[8*k+j], r);
        rd[8*k+j] = r;
      end
    end
    wait_clk(3);
    sen_b = 1'b1;
    // Released line must not keep its last value
    sdio = ~sdio;
    wait_clk(3);
  endtask : frame
endmodule : mfcfg_host
`default_nettype wire

// [dv/mfcfg_regs_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module mfcfg_regs_tb_top;
  import mfcfg_pkg::*;
  localparam logic [3:0] REV = 4'hA; // Arbitrary value
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic duplex_mode = 1'b0;
  logic default_set = 1'b0;
  logic tx_port_enable = 1'b0;
  logic rx_port_enable = 1'b0;
  logic spi_lsb_first = 1'b0;
  logic spi_four_wire = 1'b0;
  mfcfg_sample_t tx_sample = 12'h000;
  mfcfg_sample_t adc_sample = 12'h000;
  logic sclk, sen_b, host_sdio, sdio_in, sdio_out, sdio_oe, sdo_out, sdo_oe;
  logic rx_out_enable, tx_path_low_power, rx_path_low_power, low_drive, dac_out_select;
  logic tx_clk_neg_edge, rx_clk_neg_edge, tx_ls_nibble_first, rx_ls_nibble_first;
  logic rx_gain_map3;
  logic [1:0] tx_interp;
  mfcfg_sample_t dac_sample, rx_sample_out;
  mfcfg_byte_t amp_gain, amp_stage_gain, amp_stand, rx_bias;
  logic [31:0] rd;
  int num_errors = 0;
  int check_count = 0;

  // Shared data pin: device wins while it drives
  assign sdio_in = sdio_oe ? sdio_out : host_sdio;
  always #5 clk_sys = ~clk_sys;

  mfcfg_regs #(.REVISION_IDENTIFIER(REV)) dut (
    .clk_sys, .rst_b, .duplex_mode, .default_set, .tx_port_enable, .rx_port_enable,
    .sclk, .sen_b, .sdio_in, .spi_lsb_first, .spi_four_wire, .tx_sample, .adc_sample,
    .sdio_out, .sdio_oe, .sdo_out, .sdo_oe, .dac_sample, .rx_sample_out, .rx_out_enable,
    .tx_path_low_power, .rx_path_low_power, .tx_interp, .tx_clk_neg_edge, .rx_clk_neg_edge,
    .tx_ls_nibble_first, .rx_ls_nibble_first, .low_drive, .dac_out_select, .rx_gain_map3,
    .amp_gain, .amp_stage_gain, .amp_stand, .rx_bias
  );
  mfcfg_host host (
    .clk_sys, .lsb_first(spi_lsb_first), .four_wire(spi_four_wire), .sdio_rd(sdio_in),
    .sdo_out, .sclk, .sen_b, .sdio(host_sdio)
  );

  // ****************************************
  // Helpers
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic do_reset(input logic dup, input logic ds);
    tick(1);
    rst_b = 1'b0;
    duplex_mode = dup;
    default_set = ds;
    tick(6);
    rst_b = 1'b1;
    tick(2);
  endtask : do_reset

  task automatic wr(input logic [1:0] n, input logic [4:0] a, input logic [31:0] d);
    host.frame(1'b0, n, a, d, rd);
  endtask : wr

  task automatic rd_chk(input logic [1:0] n, input logic [4:0] a, input logic [31:0] exp);
    host.frame(1'b1, n, a, 32'h0, rd);
    check(rd, exp);
  endtask : rd_chk

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_defaults();
    logic [1:0] ip;
    for (int m = 0; m < 4; m++) begin
      do_reset(m[1], m[0]);
      ip = (!m[1] && m[0]) ? 2'h0 : 2'h1;
      check(tx_interp, ip);
      check(rx_gain_map3, !m[1] && m[0]);
      check({low_drive, dac_out_select}, 2'h0);
      check({amp_gain, amp_stage_gain}, 16'h4462);
      check({amp_stand, rx_bias}, 16'h0100);
      rd_chk(2'h1, 5'h0D, {16'h0, ip, 5'h0, m[1], 7'h0, m[1]});
    end
  endtask : t_defaults

  task automatic t_multi();
    do_reset(1'b1, 1'b0);
    // Data kept inside the writable masks
    wr(2'h3, 5'h13, 32'h2355_1647);
    check({amp_gain, amp_stage_gain, amp_stand, rx_bias}, 32'h2355_1647);
    spi_lsb_first = 1'b1;
    rd_chk(2'h3, 5'h10, 32'h4716_5523);
    spi_four_wire = 1'b1;
    wr(2'h0, 5'h0F, 32'h0000_000F);
    rd_chk(2'h1, 5'h0F, {16'h0, 8'h23, 4'h0, REV});
    rd_chk(2'h0, 5'h1F, 32'h0);
    spi_lsb_first = 1'b0;
    spi_four_wire = 1'b0;
  endtask : t_multi

  task automatic t_loop();
    do_reset(1'b1, 1'b0);
    tx_sample = 12'h123;
    adc_sample = 12'h9AB;
    tick(3);
    check({dac_sample, rx_sample_out}, 24'h1239_AB);
    check({rx_out_enable, tx_path_low_power, rx_path_low_power}, 3'h4);
    wr(2'h0, 5'h0D, 32'h81);
    check(dac_sample, 12'h9AB);
    wr(2'h0, 5'h0D, 32'h41);
    check(rx_sample_out, 12'h123);
    wr(2'h0, 5'h0C, 32'h47);
    check({tx_ls_nibble_first, tx_clk_neg_edge, tx_interp}, 4'hD);
    wr(2'h0, 5'h0D, 32'h22);
    check({rx_out_enable, rx_clk_neg_edge}, 2'h1);
    wr(2'h0, 5'h0E, 32'hFF);
    check({low_drive, dac_out_select}, 2'h3);
    rd_chk(2'h0, 5'h0E, 32'h81);
  endtask : t_loop

  task automatic t_half();
    do_reset(1'b0, 1'b0);
    tx_port_enable = 1'b1;
    rx_port_enable = 1'b1;
    tick(3);
    check({tx_path_low_power, rx_path_low_power, rx_out_enable}, 3'h3);
    check({dac_sample, rx_sample_out}, 24'h9231_AB);
    // Digital loopback and nibble order have no effect in half-duplex
    wr(2'h0, 5'h0D, 32'h40);
    check(rx_sample_out, 12'h1AB);
    wr(2'h0, 5'h0C, 32'h44);
    check(tx_ls_nibble_first, 1'b0);
    tx_port_enable = 1'b0;
    tick(3);
    check({tx_path_low_power, rx_path_low_power}, 2'h2);
    // Invert bits flip the enable pins before use
    wr(2'h0, 5'h0C, 32'h10);
    wr(2'h0, 5'h0D, 32'h10);
    check({tx_path_low_power, rx_path_low_power, rx_out_enable}, 3'h2);
  endtask : t_half

  initial begin
    t_defaults();
    t_multi();
    t_loop();
    t_half();
    report_and_stop();
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk_sys);
    num_errors++;
    report_and_stop();
  end
endmodule : mfcfg_regs_tb_top
`default_nettype wire
